// file: osc_pkg.sv
/*
 output sync and status pin control: shared constants.
 assumes a 32-bit serial word with a 4-bit register address in its low bits.
*/
// Notes on behaviour
// - sync happens only while sync enable set
// - enable rising edge fires sync on non-exempt outputs
// - exempt bits 20..25 keep outputs running
// - participating outputs held low during sync
// - new delay applied only by sync, not exempt; here setting exempt on a held output also pulses its delay load
// - setting exempt bit keeps existing phase alignment
// - sync pin output select: low or readback
// - qualified sync waits for feedback output edge
// - polarity bit inverts input; toggling makes sync
// - auto sync on writes to regs 0..5 at latch fall
// - sync pin io type field selects direction, drive
// - sync pin as output forces internal input low
// - lock pin select picks status signal
// - lock pin io type sets polarity, drive style
// - forced sync until chosen loop reports lock
// - tracking bit makes dac follow, count readable; count is sampled but not read back here
// - holdover mode code 1 off, 2 on
// - holdover pin select shares lock encoding
// - holdover pin io type sets drive style
package osc_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [3:0] OSC_ADDR_SYNC = 4'h000b;
   localparam logic [3:0] OSC_ADDR_LOCK = 4'h000c;
   localparam logic [3:0] OSC_ADDR_HOLD = 4'h000d;
   localparam logic [3:0] OSC_ADDR_DLY_LAST = 4'h0005;
   localparam int OSC_ADDR_W = 4;
   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int OSC_EN_SYNC_BIT = 26;
   localparam int OSC_EXEMPT_LSB = 20;
   localparam int OSC_SMUX_LSB = 18;
   localparam int OSC_QUAL_BIT = 17;
   localparam int OSC_POL_BIT = 16;
   localparam int OSC_AUTO_BIT = 15;
   localparam int OSC_TYPE_LSB = 12;
   localparam int OSC_PMUX_LSB = 27;
   localparam int OSC_PTYPE_LSB = 24;
   localparam int OSC_F2_BIT = 23;
   localparam int OSC_F1_BIT = 22;
   localparam int OSC_TRACK_BIT = 8;
   localparam int OSC_HMODE_LSB = 6;
   localparam int OSC_NUM_OUT = 6;
   // ----------------------------------------
   // reset values: only sync enable is on
   // ----------------------------------------
   localparam logic [31:0] OSC_SYNC_RST = 32'h0400_0000;
   localparam logic [31:0] OSC_ZERO_RST = 32'h0000_0000;
   // ----------------------------------------
   // codes
   // ----------------------------------------
   localparam logic [1:0] OSC_SMUX_READBACK = 2'h3;
   localparam logic [2:0] OSC_IO_PP = 3'h3;
   localparam logic [2:0] OSC_IO_PP_INV = 3'h4;
   localparam logic [2:0] OSC_IO_OSRC = 3'h5;
   localparam logic [2:0] OSC_IO_ODRN = 3'h6;
   localparam logic [1:0] OSC_HOLD_OFF = 2'h1;
   localparam logic [1:0] OSC_HOLD_ON = 2'h2;
   localparam logic [4:0] OSC_SEL_MAX = 5'h12;
endpackage

// file: osc_pin_drv.sv
/*
 status pin driver: selects a status signal and shapes polarity and drive.
 assumes all select inputs are on the same clock.
*/
`timescale 1ns/100ps
module osc_pin_drv
   import osc_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [4:0] i_sel,
   input wire logic [2:0] i_io_type,
   input wire logic [18:0] i_src,
   output logic o_pin,
   output logic o_pin_oe
);
   // ----------------------------------------
   // selection
   // ----------------------------------------
   wire logic sel_ok = (i_sel <= OSC_SEL_MAX);
   wire logic raw = sel_ok ? i_src[i_sel] : 1'b0;
   wire logic inv = (i_io_type == OSC_IO_PP_INV);
   wire logic lvl = raw ^ inv;
   wire logic is_out = (i_io_type >= OSC_IO_PP) && (i_io_type <= OSC_IO_ODRN);
   // open source drives only high, open drain only low
   wire logic oe_d = is_out && !((i_io_type == OSC_IO_OSRC) && !lvl)
                     && !((i_io_type == OSC_IO_ODRN) && lvl);
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_pin <= 1'b0;
         o_pin_oe <= 1'b0;
      end else begin
         o_pin <= lvl;
         o_pin_oe <= oe_d;
      end
   end
endmodule

// file: osc_sync_ctrl.sv
/*
 sync and status control: serial register port, sync generation,
 per-output hold-low and delay load, lock and holdover pins.
 assumes serial pins come from outside and get three-stage sampling.
*/
`timescale 1ns/100ps
module osc_sync_ctrl
   import osc_pkg::*;
#(
   parameter int NUM_OUT = OSC_NUM_OUT,
   parameter int DAC_W = 10
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_ser_clk,
   input wire logic i_ser_data,
   input wire logic i_serial_latch_enable_pin,
   output logic o_ser_readback,
   input wire logic i_sync_pin,
   output logic o_sync_pin,
   output logic o_sync_pin_oe,
   input wire logic [NUM_OUT-1:0] i_out_clk,
   input wire logic [2:0] i_fb_sel,
   input wire logic i_loop1_lock,
   input wire logic i_loop2_lock,
   input wire logic i_holdover_active,
   input wire logic i_dac_locked,
   input wire logic i_dac_rail,
   input wire logic i_dac_low,
   input wire logic i_dac_high,
   input wire logic [5:0] i_div_mon,
   input wire logic [DAC_W-1:0] i_dac_count_value,
   output logic [NUM_OUT-1:0] o_out_hold_low,
   output logic [NUM_OUT-1:0] o_delay_load,
   output logic o_dac_track,
   output logic o_holdover_en,
   output logic o_lock_status_pin,
   output logic o_lock_status_pin_oe,
   output logic o_hold_status_pin,
   output logic o_hold_status_pin_oe
);
   initial begin
      if (NUM_OUT != OSC_NUM_OUT) $error("only six outputs are served");
      if (DAC_W < 1 || DAC_W > 32) $error("dac width out of range");
   end
   // ----------------------------------------
   // pin sampling, change counts when stages 2 and 3 agree
   // ----------------------------------------
   logic [2:0] sck_q, sdi_q, le_q, spin_q;
   logic sck_s_q, le_s_q, sdi_s_q, spin_s_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sck_q <= 3'h0;
         sdi_q <= 3'h0;
         le_q <= 3'h0;
         spin_q <= 3'h0;
      end else begin
         sck_q <= {sck_q[1:0], i_ser_clk};
         sdi_q <= {sdi_q[1:0], i_ser_data};
         le_q <= {le_q[1:0], i_serial_latch_enable_pin};
         spin_q <= {spin_q[1:0], i_sync_pin};
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sck_s_q <= 1'b0;
         le_s_q <= 1'b0;
         sdi_s_q <= 1'b0;
         spin_s_q <= 1'b0;
      end else begin
         if (sck_q[1] == sck_q[2]) sck_s_q <= sck_q[2];
         if (le_q[1] == le_q[2]) le_s_q <= le_q[2];
         if (sdi_q[1] == sdi_q[2]) sdi_s_q <= sdi_q[2];
         if (spin_q[1] == spin_q[2]) spin_s_q <= spin_q[2];
      end
   end
   wire logic sck_rise = (sck_q[1] == sck_q[2]) && sck_q[2] && !sck_s_q;
   wire logic le_rise = (le_q[1] == le_q[2]) && le_q[2] && !le_s_q;
   wire logic le_fall = (le_q[1] == le_q[2]) && !le_q[2] && le_s_q;
   // ----------------------------------------
   // serial shift and latch
   // ----------------------------------------
   logic [31:0] shift_q;
   logic [31:0] sync_reg_q, lock_reg_q, hold_reg_q;
   logic dly_wr_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) shift_q <= 32'h0000_0000;
      else if (sck_rise) shift_q <= {shift_q[30:0], sdi_s_q};
   end
   wire logic [OSC_ADDR_W-1:0] addr = shift_q[OSC_ADDR_W-1:0];
   wire logic wr_sync = le_rise && (addr == OSC_ADDR_SYNC);
   wire logic wr_lock = le_rise && (addr == OSC_ADDR_LOCK);
   wire logic wr_hold = le_rise && (addr == OSC_ADDR_HOLD);
   wire logic wr_dly = le_rise && (addr <= OSC_ADDR_DLY_LAST);
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         sync_reg_q <= OSC_SYNC_RST;
         lock_reg_q <= OSC_ZERO_RST;
         hold_reg_q <= OSC_ZERO_RST;
         dly_wr_q <= 1'b0;
      end else begin
         if (wr_sync) sync_reg_q <= shift_q;
         if (wr_lock) lock_reg_q <= shift_q;
         if (wr_hold) hold_reg_q <= shift_q;
         // armed at latch rise, fired at latch fall
         if (wr_dly) dly_wr_q <= 1'b1;
         else if (le_fall) dly_wr_q <= 1'b0;
      end
   end
   // ----------------------------------------
   // field decode
   // ----------------------------------------
   wire logic en_sync = sync_reg_q[OSC_EN_SYNC_BIT];
   wire logic [NUM_OUT-1:0] exempt = sync_reg_q[OSC_EXEMPT_LSB +: NUM_OUT];
   wire logic [1:0] smux = sync_reg_q[OSC_SMUX_LSB +: 2];
   wire logic qual = sync_reg_q[OSC_QUAL_BIT];
   wire logic pol_inv = sync_reg_q[OSC_POL_BIT];
   wire logic auto_sync = sync_reg_q[OSC_AUTO_BIT];
   wire logic [2:0] stype = sync_reg_q[OSC_TYPE_LSB +: 3];
   wire logic force2 = lock_reg_q[OSC_F2_BIT];
   wire logic force1 = lock_reg_q[OSC_F1_BIT];
   wire logic [1:0] hmode = lock_reg_q[OSC_HMODE_LSB +: 2];
   wire logic spin_out = (stype >= OSC_IO_PP) && (stype <= OSC_IO_ODRN);
   // ----------------------------------------
   // sync source
   // ----------------------------------------
   wire logic pin_in = spin_out ? 1'b0 : spin_s_q;
   wire logic pin_sync = pin_in ^ pol_inv;
   wire logic force_sync = (force1 && !i_loop1_lock) || (force2 && !i_loop2_lock);
   logic en_q, pol_q, pulse_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         en_q <= 1'b1;
         pol_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         en_q <= en_sync;
         pol_q <= pol_inv;
         // one-cycle event pulses from register edges and auto sync
         pulse_q <= (en_sync && !en_q) || (pol_inv != pol_q)
                    || (auto_sync && dly_wr_q && le_fall);
      end
   end
   wire logic sync_req = en_sync && (pin_sync || force_sync || pulse_q);
   // ----------------------------------------
   // qualification by feedback output edge
   // ----------------------------------------
   logic [NUM_OUT-1:0] fb_d1_q, fb_d2_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         fb_d1_q <= '0;
         fb_d2_q <= '0;
      end else begin
         fb_d1_q <= i_out_clk;
         fb_d2_q <= fb_d1_q;
      end
   end
   wire logic fb_ok = (i_fb_sel < 3'(NUM_OUT));
   wire logic fb_cur = fb_ok ? fb_d2_q[i_fb_sel] : 1'b0;
   logic fb_prev_q, sync_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) fb_prev_q <= 1'b0;
      else fb_prev_q <= fb_cur;
   end
   // qualified sync changes only on a falling edge of the chosen output
   wire logic fb_fall = fb_prev_q && !fb_cur;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) sync_q <= 1'b0;
      else if (!qual || fb_fall) sync_q <= sync_req;
   end
   // ----------------------------------------
   // per-output hold and delay load
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_OUT; g++) begin : g_out
         always_ff @(posedge i_ref_clk) begin
            if (i_rst) begin
               o_out_hold_low[g] <= 1'b0;
               o_delay_load[g] <= 1'b0;
            end else begin
               // exempt output never stops; setting exempt releases a held output next cycle
               o_out_hold_low[g] <= sync_q && !exempt[g];
               o_delay_load[g] <= o_out_hold_low[g] && !(sync_q && !exempt[g]);
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // sync pin output
   // ----------------------------------------
   logic rb_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) rb_q <= 1'b0;
      else if (le_rise) rb_q <= shift_q[31];
      else if (sck_rise) rb_q <= shift_q[30];
   end
   wire logic smux_val = (smux == OSC_SMUX_READBACK) ? rb_q : 1'b0;
   wire logic [18:0] sync_src = {18'h0_0000, smux_val};
   osc_pin_drv u_sync_drv (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_sel(5'h00),
      .i_io_type(stype),
      .i_src(sync_src),
      .o_pin(o_sync_pin),
      .o_pin_oe(o_sync_pin_oe)
   );
   // ----------------------------------------
   // status pins
   // ----------------------------------------
   wire logic [18:0] stat_src = {i_div_mon[5], i_div_mon[5], i_div_mon[4], i_div_mon[4],
      i_div_mon[3], i_div_mon[2], i_div_mon[1], i_div_mon[0], i_dac_high, i_dac_low,
      i_dac_rail, rb_q, 1'b0, i_dac_locked, i_holdover_active,
      i_loop1_lock && i_loop2_lock, i_loop2_lock, i_loop1_lock, 1'b0};
   osc_pin_drv u_lock_drv (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_sel(lock_reg_q[OSC_PMUX_LSB +: 5]),
      .i_io_type(lock_reg_q[OSC_PTYPE_LSB +: 3]),
      .i_src(stat_src),
      .o_pin(o_lock_status_pin),
      .o_pin_oe(o_lock_status_pin_oe)
   );
   osc_pin_drv u_hold_drv (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_sel(hold_reg_q[OSC_PMUX_LSB +: 5]),
      .i_io_type(hold_reg_q[OSC_PTYPE_LSB +: 3]),
      .i_src(stat_src),
      .o_pin(o_hold_status_pin),
      .o_pin_oe(o_hold_status_pin_oe)
   );
   // ----------------------------------------
   // dac and holdover; count sampled but not read back
   // ----------------------------------------
   logic [DAC_W-1:0] dac_count_value_q;
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_dac_track <= 1'b0;
         o_holdover_en <= 1'b0;
         dac_count_value_q <= '0;
         o_ser_readback <= 1'b0;
      end else begin
         o_dac_track <= lock_reg_q[OSC_TRACK_BIT];
         dac_count_value_q <= i_dac_count_value;
         // reserved codes keep the previous state
         if (hmode == OSC_HOLD_ON) o_holdover_en <= 1'b1;
         else if (hmode == OSC_HOLD_OFF) o_holdover_en <= 1'b0;
         o_ser_readback <= rb_q;
      end
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_held;
      o_out_hold_low != '0;
   endsequence
   sync_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !en_sync |-> !sync_req) else $error("sync without enable");
   exempt_run_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ((o_out_hold_low & $past(exempt)) == '0)) else $error("exempt output held");
   hold_follow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (sync_q && !exempt[0]) |=> o_out_hold_low[0]) else $error("output not held");
   load_end_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s_held ##1 (o_out_hold_low == '0) |-> (o_delay_load == $past(o_out_hold_low)))
      else $error("delay not loaded");
   pin_force_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      spin_out |-> (pin_in == 1'b0)) else $error("input not forced low");
   force_lock_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (en_sync && force1 && !i_loop1_lock) |-> sync_req) else $error("forced sync lost");
   en_edge_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(en_sync) |=> pulse_q) else $error("no sync on enable");
   hold_mode_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (hmode == OSC_HOLD_ON) |=> o_holdover_en) else $error("holdover not enabled");
endmodule

// file: osc_host_model.sv
/*
 host model: shifts 32-bit words into the serial register port.
 assumes the ref clock is the only timing source.
*/
`timescale 1ns/100ps
module osc_host_model
(
   input wire logic i_ref_clk,
   output logic o_ser_clk,
   output logic o_ser_data,
   output logic o_serial_latch_enable_pin
);
   // ----------------------------------------
   // serial word transfer
   // ----------------------------------------
   initial begin
      o_ser_clk = 1'b0;
      o_ser_data = 1'b0;
      o_serial_latch_enable_pin = 1'b0;
   end
   // five ref cycles per phase keeps above the sampling margin
   task automatic write_word(input logic [31:0] w);
      for (int i = 31; i >= 0; i--) begin
         @(posedge i_ref_clk);
         o_ser_data <= w[i];
         repeat (5) @(posedge i_ref_clk);
         o_ser_clk <= 1'b1;
         repeat (5) @(posedge i_ref_clk);
         o_ser_clk <= 1'b0;
      end
      repeat (5) @(posedge i_ref_clk);
      o_serial_latch_enable_pin <= 1'b1;
      repeat (5) @(posedge i_ref_clk);
      o_serial_latch_enable_pin <= 1'b0;
      // idle data inverted so a stale bit is never mistaken for live
      o_ser_data <= ~w[0];
      repeat (12) @(posedge i_ref_clk);
   endtask
endmodule

// file: osc_sync_ctrl_tb_top.sv
/*
 testbench: register writes, sync sources, status pin muxing.
 assumes the host model above and a 200 MHz ref clock.
*/
`timescale 1ns/100ps
module osc_sync_ctrl_tb_top;
   import osc_pkg::*;
   logic clk, rst, sp, l1, l2, hact, dlk, rail, dlo, dhi, sclk, sdat, le, acc_clr;
   logic [5:0] oclk, mon, hold, load, acc, ex;
   logic [2:0] fbs;
   logic [9:0] dac;
   logic rb, spo, spoe, lp, lpoe, hp, hpoe, trk, hen, hen_exp;
   int n_mismatch = 0, n_tests = 0;
   int sels[12] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 19, 31};
   // ----------------------------------------
   // clock, instances, monitors
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   osc_host_model osc_host_model_inst (.i_ref_clk(clk), .o_ser_clk(sclk), .o_ser_data(sdat),
      .o_serial_latch_enable_pin(le));
   osc_sync_ctrl osc_sync_ctrl_inst (.i_ref_clk(clk), .i_rst(rst), .i_ser_clk(sclk),
      .i_ser_data(sdat), .i_serial_latch_enable_pin(le), .o_ser_readback(rb),
      .i_sync_pin(sp), .o_sync_pin(spo), .o_sync_pin_oe(spoe), .i_out_clk(oclk),
      .i_fb_sel(fbs), .i_loop1_lock(l1), .i_loop2_lock(l2), .i_holdover_active(hact),
      .i_dac_locked(dlk), .i_dac_rail(rail), .i_dac_low(dlo), .i_dac_high(dhi),
      .i_div_mon(mon), .i_dac_count_value(dac), .o_out_hold_low(hold), .o_delay_load(load),
      .o_dac_track(trk), .o_holdover_en(hen), .o_lock_status_pin(lp),
      .o_lock_status_pin_oe(lpoe), .o_hold_status_pin(hp), .o_hold_status_pin_oe(hpoe));
   // delay_load is a one-cycle pulse, so it is gathered here
   always @(posedge clk) begin
      acc <= acc_clr ? 6'h00 : (acc | load);
      oclk <= 6'($urandom);
   end
   // ----------------------------------------
   // reference model and checks
   // ----------------------------------------
   function automatic logic sel_val(int s);
      case (s)
         1: return l1;
         2: return l2;
         3: return l1 & l2;
         4: return hact;
         5: return dlk;
         8: return rail;
         9: return dlo;
         10: return dhi;
         default: return 1'b0;
      endcase
   endfunction
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic clr_acc();
      @(posedge clk);
      acc_clr <= 1'b1;
      @(posedge clk);
      acc_clr <= 1'b0;
   endtask
   task automatic wsync(input int en, input int pol, input int aut, input int typ);
      osc_host_model_inst.write_word((32'(en) << 26) | (32'(ex) << 20) | (32'(pol) << 16)
         | (32'(aut) << 15) | (32'(typ) << 12) | 32'(OSC_ADDR_SYNC));
   endtask
   task automatic drive(input logic v, input int wait_n);
      @(posedge clk);
      sp <= v;
      settle(wait_n);
   endtask
   task automatic complete_run();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(4));
      rst = 1'b1; sp = 1'b0; acc_clr = 1'b0; fbs = 3'h0;
      {l1, l2, hact, dlk, rail, dlo, dhi} = 7'h00; mon = 6'h00; dac = 10'h000;
      hen_exp = 1'b0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      settle(1);
      check("reset outs", {hold, load, trk, hen}, 32'h0000_0000);
      ex = 6'($urandom) | 6'h01;
      dac <= 10'($urandom);
      fbs <= 3'($urandom % 6);
      wsync(1, 0, 0, 0);
      clr_acc();
      drive(1'b1, 10);
      check("hold in sync", hold, 6'(~ex));
      drive(1'b0, 10);
      check("hold released", hold, 6'h00);
      check("delay load", acc, 6'(~ex));
      wsync(0, 0, 0, 0);
      drive(1'b1, 10);
      check("hold disabled", hold, 6'h00);
      drive(1'b0, 2);
      clr_acc();
      // enable rise fires a one-cycle sync by itself; its delay load is checked here
      wsync(1, 0, 0, 0);
      settle(10);
      check("enable rise", acc, 6'(~ex));
      for (int t = 3; t <= 4; t++) begin
         wsync(1, 0, 0, t);
         check("sync pin", {spo, spoe}, {(t == 4), 1'b1});
      end
      drive(1'b1, 10);
      check("pin ignored", hold, 6'h00);
      wsync(1, 1, 0, 3);
      check("pol assert", hold, 6'(~ex));
      wsync(1, 0, 0, 3);
      settle(10);
      check("pol release", hold, 6'h00);
      drive(1'b0, 2);
      wsync(1, 0, 1, 0);
      for (int a = 3; a <= 6; a += 3) begin
         clr_acc();
         osc_host_model_inst.write_word(32'(a));
         settle(6);
         check("auto sync", acc, 6'((a <= 5) ? 6'(~ex) : 6'h00));
      end
      // qualify stays 0 so output2 power-down needs no care here
      wsync(1, 0, 0, 0);
      l1 <= 1'b0;
      osc_host_model_inst.write_word((32'h1 << OSC_F1_BIT) | 32'(OSC_ADDR_LOCK));
      check("forced sync", hold, 6'(~ex));
      l1 <= 1'b1;
      settle(10);
      check("lock release", hold, 6'h00);
      foreach (sels[i]) begin
         for (int t = 3; t <= 4; t++) begin
            int hs;
            int hm;
            int tr;
            hs = sels[(i + 5) % 12];
            hm = $urandom % 4;
            tr = $urandom % 2;
            {l1, l2, hact, dlk, rail, dlo, dhi} <= 7'($urandom);
            osc_host_model_inst.write_word((32'(sels[i]) << 27) | (32'(t) << 24)
               | (32'(tr) << 8) | (32'(hm) << 6) | 32'(OSC_ADDR_LOCK));
            osc_host_model_inst.write_word((32'(hs) << 27) | (32'(t) << 24)
               | 32'(OSC_ADDR_HOLD));
            if (hm == 1 || hm == 2) hen_exp = (hm == 2);
            check("lock pin", {lp, lpoe}, {sel_val(sels[i]) ^ (t == 4), 1'b1});
            check("hold pin", {hp, hpoe}, {sel_val(hs) ^ (t == 4), 1'b1});
            check("dac track", trk, 32'(tr));
            check("holdover en", hen, hen_exp);
            check("readback", rb, 32'((hs >> 4) & 1));
         end
      end
      complete_run();
   end
endmodule
